//--- hdl/fcwp_top.sv
// Protection configuration bytes with Wishbone access and a write/erase gate
//
// Added by the designer: the Wishbone slave port.
`include "fcwp_map.svh"

module fcwp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input fcwp_pkg::fcwp_wb_req_t wb_req_i,
  output fcwp_pkg::fcwp_wb_rsp_t wb_rsp_o,
  input fcwp_pkg::fcwp_mem_req_t mem_req_i,
  output fcwp_pkg::fcwp_mem_req_t mem_req_o,
  output logic mem_blocked_o,
  output fcwp_pkg::fcwp_guard_t guard_o,
  output logic code_prot_o
);
  import fcwp_pkg::*;

  // ==========================================
  // Storage
  logic [7:0] code_low_q;
  logic [7:0] code_high_q;
  logic [7:0] write_low_q;
  logic [7:0] write_high_q;
  logic prog_mode_q;
  logic small_mem_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] blocked_cnt_q;
  fcwp_mem_req_t mem_req_q;
  logic mem_blocked_q;
  logic code_prot_q;

  // ==========================================
  // Bus decode
  logic bus_hit;
  logic bus_wr;
  logic [7:0] wbyte;
  logic [7:0] low_mask;
  logic [7:0] write_high_mask;

  assign bus_hit = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  assign bus_wr = bus_hit & wb_req_i.we;

  // Byte lane follows the low address bits so byte-wide masters work
  always_comb begin
    case (wb_req_i.adr[1:0])
      2'h0: wbyte = wb_req_i.dat[7:0];
      2'h1: wbyte = wb_req_i.dat[15:8];
      2'h2: wbyte = wb_req_i.dat[23:16];
      2'h3: wbyte = wb_req_i.dat[31:24];
      default: wbyte = 8'h00;
    endcase
  end

  logic lane_sel;
  assign lane_sel = wb_req_i.sel[wb_req_i.adr[1:0]];

  // Small parts drop blocks 2 and 3 so their bits can never be cleared
  assign low_mask = small_mem_q ? `FCWP_MASK_SMALL_LOW : `FCWP_MASK_LOW;
  // Lock bit joins the clearable set only in Program mode
  assign write_high_mask = prog_mode_q ? `FCWP_MASK_WRITE_HIGH :
                           (`FCWP_MASK_WRITE_HIGH & ~(8'h01 << `FCWP_BIT_CFG));

  // ==========================================
  // Guard bytes: clear-only, AND keeps 1->0 only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_low_q <= `FCWP_RESET_LOW;
    end else if (bus_wr && lane_sel && wb_req_i.adr == `FCWP_OFS_CODE_LOW) begin
      code_low_q <= code_low_q & (wbyte | ~low_mask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_high_q <= `FCWP_RESET_CODE_HIGH;
    end else if (bus_wr && lane_sel && wb_req_i.adr == `FCWP_OFS_CODE_HIGH) begin
      code_high_q <= code_high_q & (wbyte | ~`FCWP_MASK_CODE_HIGH);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_low_q <= `FCWP_RESET_LOW;
    end else if (bus_wr && lane_sel && wb_req_i.adr == `FCWP_OFS_WRITE_LOW) begin
      write_low_q <= write_low_q & (wbyte | ~low_mask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_high_q <= `FCWP_RESET_WRITE_HIGH;
    end else if (bus_wr && lane_sel && wb_req_i.adr == `FCWP_OFS_WRITE_HIGH) begin
      write_high_q <= write_high_q & (wbyte | ~write_high_mask);
    end
  end

  // ==========================================
  // Control register: mode and part size
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_mode_q <= 1'b0;
      small_mem_q <= 1'b0;
    end else if (bus_wr && lane_sel && wb_req_i.adr == `FCWP_OFS_CTRL) begin
      prog_mode_q <= wbyte[`FCWP_BIT_PROG_MODE];
      small_mem_q <= wbyte[`FCWP_BIT_SMALL_MEM];
    end
  end

  // ==========================================
  // Read path and acknowledge
  logic [7:0] rbyte;
  always_comb begin
    case (wb_req_i.adr)
      `FCWP_OFS_CODE_LOW: rbyte = code_low_q & `FCWP_MASK_LOW;
      `FCWP_OFS_CODE_HIGH: rbyte = code_high_q & `FCWP_MASK_CODE_HIGH;
      `FCWP_OFS_WRITE_LOW: rbyte = write_low_q & `FCWP_MASK_LOW;
      `FCWP_OFS_WRITE_HIGH: rbyte = write_high_q & `FCWP_MASK_WRITE_HIGH;
      `FCWP_OFS_CTRL: rbyte = {6'h00, small_mem_q, prog_mode_q};
      `FCWP_OFS_STATUS: rbyte = blocked_cnt_q;
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_hit;
      if (bus_hit && !wb_req_i.we) begin
        rdat_q <= {4{rbyte}};
      end
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;

  // ==========================================
  // Guard bundle for the memory controllers
  fcwp_guard_t guard;
  always_comb begin
    guard.code_block = code_low_q[3:0];
    guard.code_boot = code_high_q[`FCWP_BIT_BOOT];
    guard.code_eeprom = code_high_q[`FCWP_BIT_EEPROM];
    guard.write_block = write_low_q[3:0];
    guard.write_boot = write_high_q[`FCWP_BIT_BOOT];
    guard.write_eeprom = write_high_q[`FCWP_BIT_EEPROM];
    guard.config_write_lock = write_high_q[`FCWP_BIT_CFG];
  end

  fcwp_guard_t guard_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_q <= '1;
    end else begin
      guard_q <= guard;
    end
  end
  assign guard_o = guard_q;

  // ==========================================
  // Write and erase gate
  fcwp_region_t region;
  logic allow;
  logic code_prot;

  fcwp_region_decode u_decode (
    .addr_i(mem_req_i.addr),
    .eeprom_i(mem_req_i.eeprom),
    .region_o(region)
  );

  fcwp_guard_check u_check (
    .region_i(region),
    .guard_i(guard),
    .allow_o(allow),
    .code_prot_o(code_prot)
  );

  // One cycle of latency; a refused request never reaches the array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_q <= '0;
      mem_blocked_q <= 1'b0;
      code_prot_q <= 1'b0;
    end else begin
      mem_req_q <= mem_req_i;
      mem_req_q.valid <= mem_req_i.valid & allow;
      mem_blocked_q <= mem_req_i.valid & ~allow;
      code_prot_q <= code_prot;
    end
  end

  // Saturating count of refused requests, cleared by a status write unless a refusal increments it in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blocked_cnt_q <= 8'h00;
    end else if (mem_req_i.valid && !allow && blocked_cnt_q != 8'hFF) begin
      blocked_cnt_q <= blocked_cnt_q + 8'h01;
    end else if (bus_wr && lane_sel && wb_req_i.adr == `FCWP_OFS_STATUS) begin
      blocked_cnt_q <= 8'h00;
    end
  end

  assign mem_req_o = mem_req_q;
  assign mem_blocked_o = mem_blocked_q;
  assign code_prot_o = code_prot_q;
endmodule

//--- hdl/fcwp_map.svh
// Offsets, field positions, reset values and region bounds of the protection bytes
`ifndef FCWP_MAP_SVH
`define FCWP_MAP_SVH

// ==========================================
// Register byte offsets
`define FCWP_OFS_CODE_LOW 24'h300008
`define FCWP_OFS_CODE_HIGH 24'h300009
`define FCWP_OFS_WRITE_LOW 24'h30000A
`define FCWP_OFS_WRITE_HIGH 24'h30000B
`define FCWP_OFS_CTRL 24'h300010
`define FCWP_OFS_STATUS 24'h300011

// ==========================================
// Field positions
`define FCWP_BIT_EEPROM 7
`define FCWP_BIT_BOOT 6
`define FCWP_BIT_CFG 5
`define FCWP_BIT_PROG_MODE 0
`define FCWP_BIT_SMALL_MEM 1

// ==========================================
// Implemented bit masks and unprogrammed values
`define FCWP_MASK_LOW 8'h0F
`define FCWP_MASK_SMALL_LOW 8'h03
`define FCWP_MASK_CODE_HIGH 8'hC0
`define FCWP_MASK_WRITE_HIGH 8'hE0
`define FCWP_RESET_LOW 8'h0F
`define FCWP_RESET_CODE_HIGH 8'hC0
`define FCWP_RESET_WRITE_HIGH 8'hE0

// ==========================================
// Region bounds
`define FCWP_BOOT_LAST 24'h0007FF
`define FCWP_BLOCK0_LAST 24'h001FFF
`define FCWP_BLOCK1_LAST 24'h003FFF
`define FCWP_BLOCK2_LAST 24'h005FFF
`define FCWP_BLOCK3_LAST 24'h007FFF
`define FCWP_CFG_FIRST 24'h300000
`define FCWP_CFG_LAST 24'h3000FF

`endif

//--- hdl/fcwp_pkg.sv
// Types shared by the protection configuration block
package fcwp_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [23:0] adr;
    logic [31:0] dat;
  } fcwp_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } fcwp_wb_rsp_t;

  typedef struct packed {
    logic valid;
    logic erase;
    logic eeprom;
    logic [23:0] addr;
    logic [7:0] data;
  } fcwp_mem_req_t;

  typedef struct packed {
    logic [3:0] code_block;
    logic code_boot;
    logic code_eeprom;
    logic [3:0] write_block;
    logic write_boot;
    logic write_eeprom;
    logic config_write_lock;
  } fcwp_guard_t;

  typedef enum logic [2:0] {
    FCWP_REGION_BOOT = 3'h0,
    FCWP_REGION_BLOCK0 = 3'h1,
    FCWP_REGION_BLOCK1 = 3'h2,
    FCWP_REGION_BLOCK2 = 3'h3,
    FCWP_REGION_BLOCK3 = 3'h4,
    FCWP_REGION_CFG = 3'h5,
    FCWP_REGION_EEPROM = 3'h6,
    FCWP_REGION_NONE = 3'h7
  } fcwp_region_t;
endpackage

//--- hdl/fcwp_region_decode.sv
// Address to region decoder for program flash, configuration space and data EEPROM
`include "fcwp_map.svh"

module fcwp_region_decode (
  input wire logic [23:0] addr_i,
  input wire logic eeprom_i,
  output fcwp_pkg::fcwp_region_t region_o
);
  import fcwp_pkg::*;

  always_comb begin
    if (eeprom_i) begin
      region_o = FCWP_REGION_EEPROM;
    end else if (addr_i <= `FCWP_BOOT_LAST) begin
      region_o = FCWP_REGION_BOOT;
    end else if (addr_i <= `FCWP_BLOCK0_LAST) begin
      region_o = FCWP_REGION_BLOCK0;
    end else if (addr_i <= `FCWP_BLOCK1_LAST) begin
      region_o = FCWP_REGION_BLOCK1;
    end else if (addr_i <= `FCWP_BLOCK2_LAST) begin
      region_o = FCWP_REGION_BLOCK2;
    end else if (addr_i <= `FCWP_BLOCK3_LAST) begin
      region_o = FCWP_REGION_BLOCK3;
    end else if (addr_i >= `FCWP_CFG_FIRST && addr_i <= `FCWP_CFG_LAST) begin
      region_o = FCWP_REGION_CFG;
    end else begin
      region_o = FCWP_REGION_NONE;
    end
  end
endmodule

//--- hdl/fcwp_guard_check.sv
// Combinational verdict: is a write or erase to a region allowed by the guard bits
module fcwp_guard_check (
  input fcwp_pkg::fcwp_region_t region_i,
  input fcwp_pkg::fcwp_guard_t guard_i,
  output logic allow_o,
  output logic code_prot_o
);
  import fcwp_pkg::*;

  always_comb begin
    allow_o = 1'b1;
    code_prot_o = 1'b0;
    case (region_i)
      FCWP_REGION_BOOT: begin
        allow_o = guard_i.write_boot;
        code_prot_o = ~guard_i.code_boot;
      end
      FCWP_REGION_BLOCK0: begin
        allow_o = guard_i.write_block[0];
        code_prot_o = ~guard_i.code_block[0];
      end
      FCWP_REGION_BLOCK1: begin
        allow_o = guard_i.write_block[1];
        code_prot_o = ~guard_i.code_block[1];
      end
      FCWP_REGION_BLOCK2: begin
        allow_o = guard_i.write_block[2];
        code_prot_o = ~guard_i.code_block[2];
      end
      FCWP_REGION_BLOCK3: begin
        allow_o = guard_i.write_block[3];
        code_prot_o = ~guard_i.code_block[3];
      end
      FCWP_REGION_CFG: begin
        allow_o = guard_i.config_write_lock;
      end
      FCWP_REGION_EEPROM: begin
        allow_o = guard_i.write_eeprom;
        code_prot_o = ~guard_i.code_eeprom;
      end
      default: begin
        allow_o = 1'b1;
        code_prot_o = 1'b0;
      end
    endcase
  end
endmodule

//--- dv/fcwp_assertions.sv
// Checker of guard byte reads and the write/erase gate
module fcwp_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input fcwp_pkg::fcwp_wb_req_t wb_req_i,
  input fcwp_pkg::fcwp_wb_rsp_t wb_rsp_o,
  input fcwp_pkg::fcwp_mem_req_t mem_req_i,
  input fcwp_pkg::fcwp_mem_req_t mem_req_o,
  input wire logic mem_blocked_o,
  input fcwp_pkg::fcwp_guard_t guard_o,
  input wire logic code_prot_o
);
  import fcwp_pkg::*;
  logic [23:0] a;
  logic v;
  assign a = mem_req_i.addr;
  assign v = mem_req_i.valid && !mem_req_i.eeprom;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  function automatic logic inr(logic [23:0] x, logic [23:0] lo, logic [23:0] hi);
    return x >= lo && x <= hi;
  endfunction
  sequence blocked_s;
    mem_blocked_o && !mem_req_o.valid;
  endsequence
  // ========================================
  // Gate verdicts
  AST_BLOCK3: assert property (v && inr(a, 24'h006000, 24'h007FFF) && !guard_o.write_block[3]
    |=> blocked_s) else $error("block 3 write not refused");
  AST_BLOCK0: assert property (v && inr(a, 24'h000800, 24'h001FFF) && !guard_o.write_block[0]
    |=> blocked_s) else $error("block 0 write not refused");
  AST_EEPROM: assert property (mem_req_i.valid && mem_req_i.eeprom && !guard_o.write_eeprom
    |=> blocked_s) else $error("eeprom write not refused");
  AST_BOOT: assert property (v && a <= 24'h0007FF && !guard_o.write_boot
    |=> blocked_s) else $error("boot write not refused");
  AST_CFG: assert property (v && inr(a, 24'h300000, 24'h3000FF) && !guard_o.config_write_lock
    |=> blocked_s) else $error("config write not refused");
  AST_PASS: assert property (v && inr(a, 24'h008000, 24'h2FFFFF)
    |=> mem_req_o.valid && !mem_blocked_o && mem_req_o.addr == $past(a))
    else $error("unguarded write not passed");
  AST_CODE1: assert property (!mem_req_i.eeprom && inr(a, 24'h002000, 24'h003FFF)
    && !guard_o.code_block[1] |=> code_prot_o) else $error("block 1 code guard missed");
  // ========================================
  // Register contents
  AST_UNIMPL: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == 24'h300009
    |-> wb_rsp_o.dat[5:0] == 6'h00) else $error("unimplemented bits not zero");
  AST_CLEARONLY: assert property ((guard_o & ~$past(guard_o)) != '0 |-> $past(rst_i))
    else $error("guard bit set without reset");
endmodule

bind fcwp_top fcwp_checker chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o),
  .mem_req_i(mem_req_i),
  .mem_req_o(mem_req_o),
  .mem_blocked_o(mem_blocked_o),
  .guard_o(guard_o),
  .code_prot_o(code_prot_o)
);

//--- dv/fcwp_top_bench.sv
// Self-checking bench of the protection bytes and the write/erase gate
module fcwp_top_bench;
  import fcwp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, mem_blocked_o, code_prot_o, prog;
  fcwp_wb_req_t wb_req_i;
  fcwp_wb_rsp_t wb_rsp_o;
  fcwp_mem_req_t mem_req_i, mem_req_o;
  logic [7:0] m[4], msk[4], q, d;
  logic [23:0] base[7];
  int seed = 32'hA2988EE5;
  int fail_count = 0;
  int check_count = 0;
  int i, j, k;
  int nblk = 0;

  fcwp_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .mem_req_i(mem_req_i), .mem_req_o(mem_req_o), .mem_blocked_o(mem_blocked_o),
    .guard_o(), .code_prot_o(code_prot_o));

  always #2 clk_i = ~clk_i;

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ========================================
  // Bus cycles and reference model
  task automatic wb(logic w, logic [23:0] a, logic [7:0] dd, output logic [7:0] r);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: {4{dd}}};
    // Wait on rising edges only; the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_rsp_o.ack !== 1'b1);
    chk(wb_rsp_o.ack, 1);
    r = wb_rsp_o.dat[7:0];
    wb_req_i <= '0;
    @(posedge clk_i);
  endtask

  // Guard bit of a target: b 0 selects the code bytes, 2 the write bytes
  function automatic logic bitv(logic [23:0] a, logic e, int b);
    if (e)
      return m[b+1][7];
    if (a < 24'h000800)
      return m[b+1][6];
    if (a < 24'h008000)
      return m[b][a[14:13]];
    if (a[23:8] == 16'h3000 && b == 2)
      return m[3][5];
    return 1'b1;
  endfunction

  task automatic gate(logic [23:0] a, logic e);
    logic w, c;
    w = bitv(a, e, 2);
    c = bitv(a, e, 0);
    if (!w)
      nblk++;
    mem_req_i <= '{valid: 1'b1, erase: a[0], eeprom: e, addr: a, data: a[7:0]};
    @(posedge clk_i);
    mem_req_i.valid <= 1'b0;
    @(negedge clk_i);
    chk({mem_blocked_o, mem_req_o.valid, code_prot_o, mem_req_o.addr}, {!w, w, !c, a});
    @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    prog = 1'b0;
    wb_req_i = '0;
    mem_req_i = '0;
    m = '{8'h0F, 8'hC0, 8'h0F, 8'hE0};
    msk = '{8'h0F, 8'hC0, 8'h0F, 8'hC0};
    base = '{24'h0, 24'h800, 24'h2000, 24'h4000, 24'h6000, 24'h300000, 24'h8000};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 24'h300020, 8'h00, q);
    chk(q, 0);
    for (i = 0; i < 40; i++) begin
      // Lock bit only becomes clearable once program mode is entered halfway
      if (i == 20) begin
        wb(1'b1, 24'h300010, 8'h01, q);
        msk[3] = 8'hE0;
      end
      // Small part: blocks 2 and 3 bits keep their value
      if (i == 30) begin
        wb(1'b1, 24'h300010, 8'h03, q);
        msk[0] = 8'h03;
        msk[2] = 8'h03;
      end
      k = $unsigned($random(seed)) % 4;
      d = 8'($random(seed) | $random(seed));
      wb(1'b1, 24'h300008 + 24'(k), d, q);
      m[k] = m[k] & (d | ~msk[k]);
      for (j = 0; j < 4; j++) begin
        wb(1'b0, 24'h300008 + 24'(j), 8'h00, q);
        chk(q, m[j]);
      end
      for (j = 0; j < 8; j++)
        gate(base[j % 7] + 24'($random(seed) & 32'h0FF), j == 7);
    end
    wb(1'b0, 24'h300011, 8'h00, q);
    chk(q, (nblk > 255) ? 255 : nblk);
    close_out();
  end

  initial begin
    #50000;
    fail_count++;
    close_out();
  end
endmodule
